// ### design/imf_regs.sv
`timescale 1ns/1ps
module imf_regs (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset_n,
   // register port
   input  wire imf_pkg::imf_bus_t    bus_in,
   output logic               [31:0] rd_data_r,
   // status sources and fifo levels
   input  wire logic          [31:0] event_in,
   input  wire imf_pkg::imf_levels_t levels_in,
   // receive datapath handshakes
   input  wire logic                 rx_dword_read,
   input  wire logic                 rx_buf_done,
   input  wire logic          [11:0] rx_buf_dwords,
   // host request
   output logic                      host_irq_r,
   // receive control
   output logic                      rx_flush_r,
   output logic               [1:0]  end_align_r,
   output logic               [4:0]  rx_start_offset_r,
   output logic               [3:0]  rx_pad_dwords_r,
   output logic                      rx_pad_valid_r
);
   import imf_pkg::*;

   logic [31:0] mask_r;
   logic [31:0] level_r;
   logic [11:0] rx_dword_countdown_r;
   logic [4:0]  off_req_r;
   logic [31:0] sts_bits;
   logic [31:0] set_vec;
   logic [31:0] clr_vec;
   logic        wr_sts;
   logic        wr_mask;
   logic        wr_level;
   logic        wr_rxcfg;
   logic        tx_space_avail_irq;
   logic        tx_status_level_irq;
   logic        rx_status_level_irq;
   logic        dma_done;
   logic [3:0]  align_dw;
   logic [3:0]  pad_nxt;

   ////////////////////////////////////////////////////////////////////////
   // address decode
   assign wr_sts   = bus_in.wr && (bus_in.addr == IMF_STATUS_OFS);
   assign wr_mask  = bus_in.wr && (bus_in.addr == IMF_MASK_OFS);
   assign wr_level = bus_in.wr && (bus_in.addr == IMF_LEVEL_OFS);
   assign wr_rxcfg = bus_in.wr && (bus_in.addr == IMF_RXCFG_OFS);

   ////////////////////////////////////////////////////////////////////////
   // interrupt mask
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_r <= IMF_MASK_RST;
      end else if (wr_mask) begin
         mask_r <= bus_in.wdata & IMF_MASK_WR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fifo level thresholds
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         level_r <= IMF_LEVEL_RST;
      end else if (wr_level) begin
         level_r <= bus_in.wdata & IMF_LEVEL_WR;
      end
   end

   assign tx_space_avail_irq  = levels_in.tx_free_blocks >
      {1'b0, level_r[IMF_TX_SPACE_AVAIL_IRQ_HI:IMF_TX_SPACE_AVAIL_IRQ_LO]};
   assign tx_status_level_irq = levels_in.tx_sts_used >
      {1'b0, level_r[IMF_TX_STATUS_LEVEL_IRQ_HI:IMF_TX_STATUS_LEVEL_IRQ_LO]};
   assign rx_status_level_irq = levels_in.rx_sts_used >
      {1'b0, level_r[IMF_RX_STATUS_LEVEL_IRQ_HI:IMF_RX_STATUS_LEVEL_IRQ_LO]};

   ////////////////////////////////////////////////////////////////////////
   // receive configuration
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         end_align_r <= IMF_RXCFG_RST[IMF_ALIGN_HI:IMF_ALIGN_LO];
         off_req_r   <= IMF_RXCFG_RST[IMF_OFF_HI:IMF_OFF_LO];
      end else if (wr_rxcfg) begin
         end_align_r <= bus_in.wdata[IMF_ALIGN_HI:IMF_ALIGN_LO];
         off_req_r   <= bus_in.wdata[IMF_OFF_HI:IMF_OFF_LO];
      end
   end

   // dword countdown, write replaces, reads decrement and hold at zero
   assign dma_done = rx_dword_read && !wr_rxcfg &&
                     (rx_dword_countdown_r == IMF_CNT_ONE);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_dword_countdown_r <= IMF_RXCFG_RST[IMF_CNT_HI:IMF_CNT_LO];
      end else if (wr_rxcfg) begin
         rx_dword_countdown_r <= bus_in.wdata[IMF_CNT_HI:IMF_CNT_LO];
      end else if (rx_dword_read &&
                   rx_dword_countdown_r != IMF_CNT_ZERO) begin
         rx_dword_countdown_r <= rx_dword_countdown_r - IMF_CNT_ONE;
      end
   end

   // one-cycle flush pulse, bit reads back zero
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_flush_r <= 1'b0;
      end else begin
         rx_flush_r <= wr_rxcfg && bus_in.wdata[IMF_FLUSH_BIT];
      end
   end

   // low offset bits direct, dword bits at next dword read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_start_offset_r <= IMF_RXCFG_RST[IMF_OFF_HI:IMF_OFF_LO];
      end else begin
         rx_start_offset_r[1:0] <= off_req_r[1:0];
         if (rx_dword_read) begin
            rx_start_offset_r[4:2] <= off_req_r[4:2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // end-of-buffer padding
   always_comb begin
      case (end_align_r)
         IMF_ALIGN_4:  align_dw = IMF_DW_4;
         IMF_ALIGN_16: align_dw = IMF_DW_16;
         IMF_ALIGN_32: align_dw = IMF_DW_32;
         default:      align_dw = IMF_DW_4;
      endcase
      pad_nxt = (align_dw - (rx_buf_dwords[3:0] & (align_dw - IMF_DW_4)))
                & (align_dw - IMF_DW_4);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_pad_dwords_r <= IMF_DW_4 - IMF_DW_4;
         rx_pad_valid_r  <= 1'b0;
      end else begin
         rx_pad_valid_r <= rx_buf_done;
         if (rx_buf_done) begin
            rx_pad_dwords_r <= pad_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status
   always_comb begin
      set_vec                = event_in;
      set_vec[IMF_BIT_RXD]   = event_in[IMF_BIT_RXD]  || dma_done;
      set_vec[IMF_BIT_TX_SPACE_AVAIL_IRQ]  = event_in[IMF_BIT_TX_SPACE_AVAIL_IRQ] || tx_space_avail_irq;
      set_vec[IMF_BIT_TX_STATUS_LEVEL_IRQ]  = event_in[IMF_BIT_TX_STATUS_LEVEL_IRQ] || tx_status_level_irq;
      set_vec[IMF_BIT_RX_STATUS_LEVEL_IRQ]  = event_in[IMF_BIT_RX_STATUS_LEVEL_IRQ] || rx_status_level_irq;
      set_vec                = set_vec & IMF_MASK_WR;
      clr_vec                = wr_sts ? bus_in.wdata : IMF_ZERO;
   end

   imf_sticky #(
      .W (32)
   ) u_status (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .set_in  (set_vec),
      .clr_in  (clr_vec),
      .bits_r  (sts_bits)
   );

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_irq_r <= 1'b0;
      end else begin
         host_irq_r <= |(sts_bits & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_r <= IMF_ZERO;
      end else if (bus_in.rd) begin
         case (bus_in.addr)
            IMF_STATUS_OFS: rd_data_r <= sts_bits;
            IMF_MASK_OFS:   rd_data_r <= mask_r;
            IMF_PROBE_OFS:  rd_data_r <= IMF_PROBE_VAL;
            IMF_LEVEL_OFS:  rd_data_r <= level_r;
            IMF_RXCFG_OFS:  rd_data_r <= {end_align_r, 2'h0,
                                          rx_dword_countdown_r, 3'h0,
                                          off_req_r, 8'h00};
            default:        rd_data_r <= IMF_ZERO;
         endcase
      end else begin
         rd_data_r <= IMF_ZERO;
      end
   end

endmodule // imf_regs

// ### design/imf_pkg.sv
package imf_pkg;

   // register offsets
   localparam logic [7:0]  IMF_STATUS_OFS = 8'h58;
   localparam logic [7:0]  IMF_MASK_OFS   = 8'h5c;
   localparam logic [7:0]  IMF_PROBE_OFS  = 8'h64;
   localparam logic [7:0]  IMF_LEVEL_OFS  = 8'h68;
   localparam logic [7:0]  IMF_RXCFG_OFS  = 8'h6c;

   // writable masks and reset values
   localparam logic [31:0] IMF_MASK_WR    = 32'h83bfe7df;
   localparam logic [31:0] IMF_MASK_RST   = 32'h00000000;
   localparam logic [31:0] IMF_PROBE_VAL  = 32'h87654321;
   localparam logic [31:0] IMF_LEVEL_WR   = 32'hffff00ff;
   localparam logic [31:0] IMF_LEVEL_RST  = 32'h48000000;
   localparam logic [31:0] IMF_RXCFG_WR   = 32'hcfff1f00;
   localparam logic [31:0] IMF_RXCFG_RST  = 32'h00000000;
   localparam logic [31:0] IMF_ZERO       = 32'h00000000;

   // status bit positions driven inside the block
   localparam int IMF_BIT_RXD   = 20;
   localparam int IMF_BIT_TX_SPACE_AVAIL_IRQ  = 9;
   localparam int IMF_BIT_TX_STATUS_LEVEL_IRQ  = 7;
   localparam int IMF_BIT_RX_STATUS_LEVEL_IRQ  = 3;

   // field positions
   localparam int IMF_ALIGN_HI  = 31;
   localparam int IMF_ALIGN_LO  = 30;
   localparam int IMF_CNT_HI    = 27;
   localparam int IMF_CNT_LO    = 16;
   localparam int IMF_FLUSH_BIT = 15;
   localparam int IMF_OFF_HI    = 12;
   localparam int IMF_OFF_LO    = 8;
   localparam int IMF_TX_SPACE_AVAIL_IRQ_HI   = 31;
   localparam int IMF_TX_SPACE_AVAIL_IRQ_LO   = 24;
   localparam int IMF_TX_STATUS_LEVEL_IRQ_HI   = 23;
   localparam int IMF_TX_STATUS_LEVEL_IRQ_LO   = 16;
   localparam int IMF_RX_STATUS_LEVEL_IRQ_HI   = 7;
   localparam int IMF_RX_STATUS_LEVEL_IRQ_LO   = 0;

   // alignment codes and their size in dwords
   localparam logic [1:0]  IMF_ALIGN_4    = 2'h0;
   localparam logic [1:0]  IMF_ALIGN_16   = 2'h1;
   localparam logic [1:0]  IMF_ALIGN_32   = 2'h2;
   localparam logic [3:0]  IMF_DW_4       = 4'h1;
   localparam logic [3:0]  IMF_DW_16      = 4'h4;
   localparam logic [3:0]  IMF_DW_32      = 4'h8;
   localparam logic [11:0] IMF_CNT_ONE    = 12'h001;
   localparam logic [11:0] IMF_CNT_ZERO   = 12'h000;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } imf_bus_t;

   typedef struct packed {
      logic [8:0] tx_free_blocks;
      logic [8:0] tx_sts_used;
      logic [8:0] rx_sts_used;
   } imf_levels_t;

endpackage

// ### design/imf_sticky.sv
`timescale 1ns/1ps
module imf_sticky #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   // set and clear strobes
   input  wire logic [W-1:0] set_in,
   input  wire logic [W-1:0] clr_in,
   // held bits
   output logic      [W-1:0] bits_r
);
   import imf_pkg::*;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               bits_r[i] <= 1'b0;
            end else if (set_in[i]) begin
               bits_r[i] <= 1'b1;
            end else if (clr_in[i]) begin
               bits_r[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule // imf_sticky

// ### sim/imf_chk.sv
`timescale 1ns/1ps
module imf_chk (
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              reset_n,
   // register port
   input wire imf_pkg::imf_bus_t bus_in,
   input wire logic [31:0]       rd_data_r,
   // receive side and request
   input wire logic              rx_buf_done,
   input wire logic [11:0]       rx_buf_dwords,
   input wire logic              rx_dword_read,
   input wire logic              host_irq_r,
   input wire logic              rx_flush_r,
   input wire logic [1:0]        end_align_r,
   input wire logic [4:0]        rx_start_offset_r,
   input wire logic [3:0]        rx_pad_dwords_r,
   input wire logic              rx_pad_valid_r
);
   import imf_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   sequence s_cfg_wr;
      bus_in.wr && bus_in.addr == IMF_RXCFG_OFS;
   endsequence
   sequence s_mask_off;
      bus_in.wr && bus_in.addr == IMF_MASK_OFS && bus_in.wdata == IMF_ZERO;
   endsequence
   ////////////////////////////////////////////////////////////
   chk_probe_read: assert property (
      bus_in.rd && bus_in.addr == IMF_PROBE_OFS |=> rd_data_r == IMF_PROBE_VAL)
      else $error("probe read wrong");
   chk_read_quiet: assert property (
      !bus_in.rd |=> rd_data_r == IMF_ZERO) else $error("read data not idle");
   chk_mask_off: assert property (
      s_mask_off |=> ##1 !host_irq_r) else $error("request with mask clear");
   chk_flush_pulse: assert property (
      s_cfg_wr ##0 bus_in.wdata[IMF_FLUSH_BIT] |=> rx_flush_r)
      else $error("flush missing");
   chk_flush_clear: assert property (
      rx_flush_r && !bus_in.wr |=> !rx_flush_r) else $error("flush stuck");
   chk_pad_valid: assert property (
      rx_buf_done |=> rx_pad_valid_r) else $error("pad valid missing");
   chk_pad_none: assert property (
      rx_buf_done && end_align_r[0] == end_align_r[1]
      |=> rx_pad_dwords_r == 4'h0) else $error("pad for 4 byte");
   chk_pad_sixteen: assert property (
      rx_buf_done && end_align_r == IMF_ALIGN_16 |=>
      rx_pad_dwords_r == {2'h0, 2'h0 - $past(rx_buf_dwords[1:0])})
      else $error("pad for 16 byte");
   chk_pad_wide: assert property (
      rx_buf_done && end_align_r == IMF_ALIGN_32 |=>
      rx_pad_dwords_r == {1'h0, 3'h0 - $past(rx_buf_dwords[2:0])})
      else $error("pad for 32 byte");
   chk_offset_low: assert property (
      s_cfg_wr ##1 !bus_in.wr |=>
      rx_start_offset_r[1:0] == $past(bus_in.wdata[9:8], 2))
      else $error("offset low bits");
   chk_offset_hold: assert property (
      !rx_dword_read |=> $stable(rx_start_offset_r[4:2]))
      else $error("dword offset moved without read");
   chk_flush_only: assert property (
      !(bus_in.wr && bus_in.addr == IMF_RXCFG_OFS &&
        bus_in.wdata[IMF_FLUSH_BIT]) |=> !rx_flush_r)
      else $error("flush without request");
   chk_valid_only: assert property (
      !rx_buf_done |=> !rx_pad_valid_r) else $error("pad valid unasked");
endmodule // imf_chk
bind imf_regs imf_chk imf_chk_i (.*);

// ### sim/imf_host.sv
`timescale 1ns/1ps
module imf_host (
   // clock
   input wire logic          ref_clk,
   // register port
   output imf_pkg::imf_bus_t bus_o,
   input wire logic [31:0]   rd_data_r
);
   import imf_pkg::*;
   initial bus_o = '0;
   // released bus shows inverted leftovers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_o <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk);
      bus_o <= '{~a, ~d, 1'b0, 1'b0};
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      bus_o <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge ref_clk);
      bus_o <= '{~a, 32'hffffffff, 1'b0, 1'b0};
      @(posedge ref_clk);
      d = rd_data_r;
   endtask
endmodule // imf_host

// ### sim/irq_mask_fifo_level_rx_config_tb.sv
`timescale 1ns/1ps
module irq_mask_fifo_level_rx_config_tb;
   import imf_pkg::*;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   imf_bus_t    bus_in;
   imf_levels_t levels_in = '0;
   logic [31:0] rd_data_r, d, event_in = '0;
   logic [11:0] rx_buf_dwords = '0;
   logic        rx_dword_read = 1'b0, rx_buf_done = 1'b0;
   logic        host_irq_r, rx_flush_r, rx_pad_valid_r;
   logic [1:0]  end_align_r;
   logic [4:0]  rx_start_offset_r;
   logic [3:0]  rx_pad_dwords_r;
   int          n_fail = 0, total_checks = 0, cycles = 0, b, n;
   int          n_flush = 0;
   imf_regs imf_regs_i (.*);
   imf_host imf_host_i (.ref_clk, .bus_o(bus_in), .rd_data_r);
   always #5 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      imf_host_i.wr(a, v);
   endtask
   task automatic rd(input logic [7:0] a);
      imf_host_i.rd(a, d);
   endtask
   task automatic pulse_rd();
      rx_dword_read <= 1'b1;
      @(posedge ref_clk);
      rx_dword_read <= 1'b0;
      @(posedge ref_clk);
   endtask
   function automatic logic [31:0] pad(input int a, input int k);
      int m;
      m = (a == 1) ? 4 : (a == 2) ? 8 : 1;
      return 32'((m - k % m) % m);
   endfunction
   always @(posedge ref_clk) begin
      cycles++;
      if (rx_flush_r) n_flush++;
      if (cycles == 20000) begin
         n_fail++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(6877));
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(IMF_PROBE_OFS);
      chk(d, IMF_PROBE_VAL);
      wr(IMF_PROBE_OFS, 32'h0);
      rd(IMF_PROBE_OFS);
      chk(d, IMF_PROBE_VAL);
      rd(8'h60);
      chk(d, IMF_ZERO);
      rd(IMF_MASK_OFS);
      chk(d, IMF_MASK_RST);
      rd(IMF_LEVEL_OFS);
      chk(d, IMF_LEVEL_RST);
      for (int i = 0; i < 4; i++) begin
         n = $urandom;
         wr(IMF_MASK_OFS, n);
         rd(IMF_MASK_OFS);
         chk(d, n & IMF_MASK_WR);
         wr(IMF_LEVEL_OFS, n);
         rd(IMF_LEVEL_OFS);
         chk(d, n & IMF_LEVEL_WR);
      end
      wr(IMF_MASK_OFS, 32'h0);
      for (int i = 0; i < 8; i++) begin
         do b = $urandom_range(31); while (!IMF_MASK_WR[b]);
         event_in[b] <= 1'b1;
         @(posedge ref_clk);
         event_in[b] <= 1'b0;
         repeat (2) @(posedge ref_clk);
         chk(host_irq_r, 32'h0);
         rd(IMF_STATUS_OFS);
         chk(d, 32'h1 << b);
         wr(IMF_STATUS_OFS, ~(32'h1 << b));
         rd(IMF_STATUS_OFS);
         chk(d, 32'h1 << b);
         wr(IMF_MASK_OFS, 32'h1 << b);
         @(posedge ref_clk);
         chk(host_irq_r, 32'h1);
         wr(IMF_STATUS_OFS, 32'h1 << b);
         @(posedge ref_clk);
         chk(host_irq_r, 32'h0);
         wr(IMF_MASK_OFS, 32'h0);
      end
      wr(IMF_LEVEL_OFS, 32'h05030002);
      for (int k = 0; k < 2; k++) begin
         levels_in <= '{9'(5 + k), 9'(3 + k), 9'(2 + k)};
         repeat (2) @(posedge ref_clk);
         rd(IMF_STATUS_OFS);
         chk(d & 32'h288, k ? 32'h288 : 32'h0);
      end
      levels_in <= '0;
      wr(IMF_STATUS_OFS, 32'hffffffff);
      wr(IMF_RXCFG_OFS, 32'h00030000);
      repeat (3) pulse_rd();
      rd(IMF_STATUS_OFS);
      chk(d, 32'h1 << IMF_BIT_RXD);
      wr(IMF_STATUS_OFS, 32'hffffffff);
      wr(IMF_RXCFG_OFS, 32'h00020000);
      pulse_rd();
      wr(IMF_RXCFG_OFS, 32'h00058000);
      pulse_rd();
      rd(IMF_RXCFG_OFS);
      chk(d, 32'h00040000);
      chk(n_flush, 32'h1);
      rd(IMF_STATUS_OFS);
      chk(d, IMF_ZERO);
      wr(IMF_RXCFG_OFS, 32'h00000c00);
      chk(rx_start_offset_r, 32'h0);
      pulse_rd();
      chk(rx_start_offset_r, 32'h0c);
      // receiver idle while low offset bits move
      wr(IMF_RXCFG_OFS, 32'h00000e00);
      pulse_rd();
      chk(rx_start_offset_r, 32'h0e);
      for (int a = 0; a < 4; a++) begin
         // alignment moves only between buffers
         wr(IMF_RXCFG_OFS, {2'(a), 30'h0});
         chk(end_align_r, 32'(a));
         for (int j = 0; j < 4; j++) begin
            n = j ? $urandom_range(4095) : 8;
            rx_buf_dwords <= 12'(n);
            rx_buf_done <= 1'b1;
            @(posedge ref_clk);
            rx_buf_done <= 1'b0;
            @(posedge ref_clk);
            // host drops these pad dwords
            chk(rx_pad_valid_r, 32'h1);
            chk(rx_pad_dwords_r, pad(a, n));
         end
      end
      summarize();
   end
endmodule // irq_mask_fifo_level_rx_config_tb
